/* snv_filter.v */
/*
 * Two-flop synchroniser followed by a unanimous (all-agree) deglitch filter for one
 * bus input. Assumes i_pin is asynchronous to i_clk.
 */
`timescale 1ns/1ps
`include "snv_map.vh"

module snv_filter (
  input  wire i_clk,
  input  wire i_rstn,
  input  wire i_pin,
  output reg  o_lvl
);

  reg                     meta_r;
  reg                     sync_r;
  reg [`SNV_FILT_LEN-1:0] hist_r;

  // ----------------------------------------
  // Sync and filter
  // ----------------------------------------
  // Output only moves when the whole history agrees; short spikes die here.
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      hist_r <= {`SNV_FILT_LEN{1'b1}};
      o_lvl  <= 1'b1;
    end else begin
      meta_r <= i_pin;
      sync_r <= meta_r;
      hist_r <= {hist_r[`SNV_FILT_LEN-2:0], sync_r};
      if (&hist_r) begin
        o_lvl <= 1'b1;
      end else if (~|hist_r) begin
        o_lvl <= 1'b0;
      end
    end
  end

endmodule // snv_filter

/* snv_map.vh */
/*
 * Constants for the two-wire nonvolatile byte memory slave: array size,
 * command byte fields, filter length and bit counts.
 * Assumes nothing of its surroundings; definitions only.
 */
`ifndef SNV_MAP_VH
`define SNV_MAP_VH

// ----------------------------------------
// Array
// ----------------------------------------
`define SNV_DEPTH        2048
`define SNV_AW           11
`define SNV_DW           8

// ----------------------------------------
// Command byte fields
// ----------------------------------------
`define SNV_TYPE_HI      7
`define SNV_TYPE_LO      4
`define SNV_UPA_HI       3
`define SNV_UPA_LO       1
`define SNV_RW_BIT       0
// Type code value is arbitrary, chosen for this block only
`define SNV_TYPE_CODE    4'h5

// ----------------------------------------
// Timing
// ----------------------------------------
`define SNV_FILT_LEN     3
`define SNV_BIT_LAST     4'h8
`define SNV_ACK_BIT      4'h9

`endif

/* snv_master.sv */
/* Two-wire bus master model, one tick T per phase.
   Assumes a pull-up on the resolved data wire. */
`timescale 1ns/1ps
module snv_master #(parameter int T = 64) (
  output reg  o_scl,
  output reg  o_pull,
  input  wire i_sda
);
  initial o_scl = 1'b1;
  initial o_pull = 1'b0;
  // Also a repeated start: release data first, then fall while clock high
  task start;
    #T o_pull = 1'b0;
    #T o_scl = 1'b1;
    #T o_pull = 1'b1;
    #T o_scl = 1'b0;
  endtask
  task stop;
    #T o_pull = 1'b1;
    #T o_scl = 1'b1;
    #T o_pull = 1'b0;
    #T;
  endtask
  task xbit(input b, output s);
    #T o_pull = ~b;
    #T o_scl = 1'b1;
    #T s = i_sda;
    o_scl = 1'b0;
  endtask
  task put_byte(input [7:0] b, output ack);
    reg s;
    for (int i = 7; i >= 0; i--) xbit(b[i], s);
    xbit(1'b1, s);
    ack = ~s;
  endtask
  task get_byte(input last, output [7:0] d);
    reg s;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, s);
      d[i] = s;
    end
    xbit(last, s);
  endtask
endmodule // snv_master

/* snv_slave.v */
/*
 * Two-wire serial slave in front of a 2048 x 8 nonvolatile byte array.
 * Assumes one bus master drives SCL, SDA is open drain with an external
 * pull-up, and the clock runs far faster than SCL.
 */
`timescale 1ns/1ps
`include "snv_map.vh"

module snv_slave (
  input  wire i_clk,
  input  wire i_rstn,
  input  wire i_scl,
  input  wire i_sda,
  input  wire i_wp,
  output reg  o_sda,
  output reg  o_sda_oe_n
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_CMD  = 3'h1;
  localparam [2:0] ST_ADDR = 3'h2;
  localparam [2:0] ST_WDAT = 3'h3;
  localparam [2:0] ST_RDAT = 3'h4;

  wire scl_f;
  wire sda_f;
  wire wp_f;

  reg             scl_d_r;
  reg             sda_d_r;
  reg  [2:0]      st_r;
  reg  [3:0]      bit_r;
  reg  [7:0]      sh_r;
  reg  [7:0]      tx_r;
  reg             rel_r;
  reg             pend_r;
  reg  [`SNV_AW-1:0] addr_r;
  reg  [`SNV_DW-1:0] mem [0:`SNV_DEPTH-1];

  // ----------------------------------------
  // Input conditioning
  // ----------------------------------------
  snv_filter u_scl (.i_clk(i_clk), .i_rstn(i_rstn), .i_pin(i_scl), .o_lvl(scl_f));
  snv_filter u_sda (.i_clk(i_clk), .i_rstn(i_rstn), .i_pin(i_sda), .o_lvl(sda_f));
  // An open pin reads low because the pad pull-down is modelled by 1'b0 on X/Z
  snv_filter u_wp  (.i_clk(i_clk), .i_rstn(i_rstn), .i_pin(i_wp === 1'b1),
                    .o_lvl(wp_f));

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_f;
      sda_d_r <= sda_f;
    end
  end

  // ----------------------------------------
  // Bus events
  // ----------------------------------------
  wire scl_rise = scl_f & ~scl_d_r;
  wire scl_fall = ~scl_f & scl_d_r;
  wire start_c  = scl_f & scl_d_r & sda_d_r & ~sda_f;
  wire stop_c   = scl_f & scl_d_r & ~sda_d_r & sda_f;

  // ----------------------------------------
  // Address and field helpers
  // ----------------------------------------
  function [`SNV_AW-1:0] addr_inc;
    input [`SNV_AW-1:0] a;
    begin
      addr_inc = a + {{(`SNV_AW-1){1'b0}}, 1'b1};
    end
  endfunction

  // Type field of a command byte against the fixed code
  function type_ok;
    input [7:0] b;
    begin
      type_ok = (b[`SNV_TYPE_HI:`SNV_TYPE_LO] == `SNV_TYPE_CODE);
    end
  endfunction

  // Direction bit of a command byte
  function is_read;
    input [7:0] b;
    begin
      is_read = b[`SNV_RW_BIT];
    end
  endfunction

  // ----------------------------------------
  // Byte framing
  // ----------------------------------------
  // The buffer keeps the last accessed address; a freshly loaded one is used
  // as is, otherwise the next access goes one further
  wire [7:0]         rx_byte  = {sh_r[6:0], sda_f};
  wire [`SNV_AW-1:0] acc_a    = pend_r ? addr_r : addr_inc(addr_r);
  wire [`SNV_DW-1:0] rd_byte  = mem[acc_a];
  wire               busy     = (st_r != ST_IDLE);
  wire               byte_end = scl_fall && (bit_r == `SNV_BIT_LAST);
  wire               ack_end  = scl_fall && (bit_r == `SNV_ACK_BIT);
  wire               mem_we   = !start_c && !stop_c && byte_end &&
                                (st_r == ST_WDAT) && !wp_f;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  reg [2:0]          st_nxt;
  reg [3:0]          bit_nxt;
  reg [7:0]          sh_nxt;
  reg [7:0]          tx_nxt;
  reg                rel_nxt;
  reg                pend_nxt;
  reg [`SNV_AW-1:0]  addr_nxt;
  reg                oe_n_nxt;

  // Start and stop win over everything, so a cut frame always ends cleanly
  always @* begin
    st_nxt  = st_r;
    bit_nxt = bit_r;
    if (start_c) begin
      st_nxt  = ST_CMD;
      bit_nxt = 4'h0;
    end else if (stop_c) begin
      st_nxt  = ST_IDLE;
      bit_nxt = 4'h0;
    end else if (busy && scl_rise) begin
      if (bit_r < `SNV_BIT_LAST) begin
        bit_nxt = bit_r + 4'h1;
      end else begin
        bit_nxt = `SNV_ACK_BIT;
      end
    end else if (busy && byte_end) begin
      case (st_r)
        ST_CMD: begin
          if (!type_ok(sh_r)) begin
            st_nxt = ST_IDLE;
          end else if (is_read(sh_r)) begin
            st_nxt = ST_RDAT;
          end else begin
            st_nxt = ST_ADDR;
          end
        end
        ST_ADDR: begin
          st_nxt = ST_WDAT;
        end
        default: begin
          st_nxt = st_r;
        end
      endcase
    end else if (busy && ack_end) begin
      bit_nxt = 4'h0;
      if (rel_r) begin
        st_nxt = ST_IDLE;
      end
    end
  end

  // ----------------------------------------
  // Data path next values
  // ----------------------------------------
  // Sampling only on rising SCL; the master owns the low phase
  always @* begin
    sh_nxt   = sh_r;
    rel_nxt  = rel_r;
    pend_nxt = pend_r;
    addr_nxt = addr_r;
    if (start_c) begin
      rel_nxt = 1'b0;
    end else if (stop_c) begin
      rel_nxt  = 1'b0;
      pend_nxt = 1'b0;
    end else if (busy && scl_rise) begin
      if (bit_r < `SNV_BIT_LAST) begin
        sh_nxt = rx_byte;
      end else if (st_r == ST_RDAT && sda_f) begin
        rel_nxt = 1'b1;
      end
    end else if (busy && byte_end) begin
      case (st_r)
        ST_CMD: begin
          if (type_ok(sh_r)) begin
            addr_nxt[10:8] = sh_r[`SNV_UPA_HI:`SNV_UPA_LO];
          end
        end
        ST_ADDR: begin
          addr_nxt[7:0] = sh_r;
          pend_nxt      = 1'b1;
        end
        ST_WDAT: begin
          addr_nxt = acc_a;
          pend_nxt = 1'b0;
        end
        default: begin
          pend_nxt = pend_r;
        end
      endcase
    end else if (busy && ack_end && st_r == ST_RDAT && !rel_r) begin
      addr_nxt = acc_a;
      pend_nxt = 1'b0;
    end
  end

  // ----------------------------------------
  // Pin drive next values
  // ----------------------------------------
  // Every change here follows a filtered SCL fall, or a start or stop for the release, never a rise
  always @* begin
    tx_nxt   = tx_r;
    oe_n_nxt = o_sda_oe_n;
    if (start_c || stop_c) begin
      oe_n_nxt = 1'b1;
    end else if (busy && byte_end) begin
      if (st_r == ST_RDAT || (st_r == ST_CMD && !type_ok(sh_r))) begin
        oe_n_nxt = 1'b1;
      end else begin
        oe_n_nxt = 1'b0;
      end
    end else if (busy && ack_end) begin
      if (st_r == ST_RDAT && !rel_r) begin
        tx_nxt   = {rd_byte[6:0], 1'b0};
        oe_n_nxt = rd_byte[7];
      end else begin
        oe_n_nxt = 1'b1;
      end
    end else if (busy && scl_fall && st_r == ST_RDAT && !rel_r) begin
      tx_nxt   = {tx_r[6:0], 1'b0};
      oe_n_nxt = tx_r[7];
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Slave only: nothing moves unless the master's clock or a condition does
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r  <= ST_IDLE;
      bit_r <= 4'h0;
    end else begin
      st_r  <= st_nxt;
      bit_r <= bit_nxt;
    end
  end

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sh_r   <= 8'h00;
      rel_r  <= 1'b0;
      pend_r <= 1'b0;
      addr_r <= {`SNV_AW{1'b0}};
    end else begin
      sh_r   <= sh_nxt;
      rel_r  <= rel_nxt;
      pend_r <= pend_nxt;
      addr_r <= addr_nxt;
    end
  end

  // The data pin is only ever pulled low, never driven high
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_r       <= 8'h00;
      o_sda      <= 1'b0;
      o_sda_oe_n <= 1'b1;
    end else begin
      tx_r       <= tx_nxt;
      o_sda      <= 1'b0;
      o_sda_oe_n <= oe_n_nxt;
    end
  end

  // ----------------------------------------
  // Array
  // ----------------------------------------
  // Own process so the array carries no reset; reads ignore write protect
  always @(posedge i_clk) begin
    if (mem_we) begin
      mem[acc_a] <= sh_r;
    end
  end

endmodule // snv_slave

/* snv_slave_sva.sv */
/* Pin checker for snv_slave.
   Assumes the master moves SDA only while SCL is low, except at start and stop. */
`timescale 1ns/1ps
`include "snv_map.vh"
module snv_slave_sva (
  input wire i_clk,
  input wire i_rstn,
  input wire i_scl,
  input wire i_sda,
  input wire i_wp,
  input wire o_sda,
  input wire o_sda_oe_n
);
  reg       scl_q;
  reg       sda_q;
  reg       first;
  reg [3:0] cnt;
  reg [7:0] sh;
  reg [7:0] cmd;
  wire rise  = i_scl & ~scl_q;
  wire sta   = scl_q & i_scl & sda_q & ~i_sda;
  wire sto   = scl_q & i_scl & ~sda_q & i_sda;
  wire ninth = rise & (cnt == 4'h8);
  wire [3:0] typ = first ? sh[7:4] : cmd[7:4];
  // Raw pins are used so that the checker does not share the filter's latency
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      first <= 1'b0;
      cnt   <= 4'h0;
      sh    <= 8'h00;
      cmd   <= 8'h00;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
      if (sta) begin
        cnt   <= 4'h0;
        first <= 1'b1;
      end else if (ninth) begin
        cnt   <= 4'h0;
        first <= 1'b0;
        if (first) cmd <= sh;
      end else if (rise) begin
        cnt <= cnt + 4'h1;
        sh  <= {sh[6:0], i_sda};
      end
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  AST_OD_ZERO: assert property (!o_sda_oe_n |-> o_sda == 1'b0)
    else $error("data pin driven high");
  AST_FALL_ONLY: assert property ($changed(o_sda_oe_n) |-> !i_scl && $past(i_scl, 3) == 1'b0)
    else $error("data output moved outside clock low");
  AST_START_FREE: assert property (sta |-> o_sda_oe_n [*8])
    else $error("data pulled at start");
  AST_CMD_ACK: assert property (ninth && first && sh[7:4] == `SNV_TYPE_CODE |-> !o_sda_oe_n)
    else $error("command byte not acknowledged");
  AST_BAD_TYPE: assert property (ninth && typ != `SNV_TYPE_CODE |-> o_sda_oe_n)
    else $error("foreign type acknowledged");
  AST_WR_ACK: assert property (ninth && !first && !cmd[0] && typ == `SNV_TYPE_CODE |-> !o_sda_oe_n)
    else $error("write byte not acknowledged");
  AST_RD_FREE: assert property (ninth && !first && cmd[0] |-> o_sda_oe_n)
    else $error("data held on ninth clock of read");
  AST_STOP_IDLE: assert property (sto |=> o_sda_oe_n [*8])
    else $error("data pulled after stop");
  cover property (ninth && !first && cmd[0]);
  cover property (ninth && !first && !cmd[0] && i_wp);
  cover property (ninth && first && sh[7:4] != `SNV_TYPE_CODE);
  cover property (sto);
endmodule // snv_slave_sva
bind snv_slave snv_slave_sva u_sva (.i_clk(i_clk), .i_rstn(i_rstn), .i_scl(i_scl),
  .i_sda(i_sda), .i_wp(i_wp), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n));

/* snv_slave_tb.sv */
/* Self-checking bench for snv_slave.
   Assumes the master model and a pull-up on the data wire. */
`timescale 1ns/1ps
`include "snv_map.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module snv_slave_tb;
  reg  i_clk, i_rstn, i_wp;
  wire scl, pull, o_sda, o_sda_oe_n;
  wire sda = ~(pull | (~o_sda_oe_n & ~o_sda));
  int  n_errors = 0;
  int  n_checks = 0;
  snv_slave dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_scl(scl), .i_sda(sda), .i_wp(i_wp),
    .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n));
  snv_master #(.T(64)) m (.o_scl(scl), .o_pull(pull), .i_sda(sda));
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  task set_wp(input v);
    @(posedge i_clk);
    #1 i_wp = v;
  endtask
  task addr(input [10:0] a);
    reg k;
    m.start();
    m.put_byte({`SNV_TYPE_CODE, a[10:8], 1'b0}, k);
    `CHK(k, 1'b1)
    m.put_byte(a[7:0], k);
    `CHK(k, 1'b1)
  endtask
  task wr(input [10:0] a, input [23:0] d, input int n);
    reg k;
    addr(a);
    for (int i = 0; i < n; i++) begin
      m.put_byte(d[23-8*i -: 8], k);
      `CHK(k, 1'b1)
    end
    m.stop();
  endtask
  // Reads straight after a write, with no wait, since no busy period exists
  task rd(input [10:0] a, input cur, input [23:0] e, input int n);
    reg k;
    reg [7:0] d;
    if (!cur) addr(a);
    m.start();
    m.put_byte({`SNV_TYPE_CODE, a[10:8], 1'b1}, k);
    `CHK(k, 1'b1)
    for (int i = 0; i < n; i++) begin
      m.get_byte(i == n - 1, d);
      `CHK(d, e[23-8*i -: 8])
    end
    m.stop();
  endtask
  task t_wrap;
    set_wp(1'b0);
    wr(11'h7fe, 24'h112233, 3);
    rd(11'h7fe, 1'b0, 24'h112233, 3);
    $display("wrap test done");
  endtask
  task t_prot;
    wr(11'h005, 24'h3cc300, 2);
    set_wp(1'b1);
    wr(11'h005, 24'ha50000, 1);
    rd(11'h005, 1'b0, 24'h3c0000, 1);
    rd(11'h005, 1'b1, 24'hc30000, 1);
    set_wp(1'bz);
    wr(11'h005, 24'h5a0000, 1);
    rd(11'h005, 1'b0, 24'h5a0000, 1);
    $display("protect test done");
  endtask
  task t_abort;
    reg s;
    m.start();
    for (int i = 0; i < 4; i++) m.xbit(1'b1, s);
    m.stop();
    m.start();
    m.put_byte({~`SNV_TYPE_CODE, 4'h0}, s);
    `CHK(s, 1'b0)
    m.stop();
    rd(11'h005, 1'b0, 24'h5a0000, 1);
    $display("abort test done");
  endtask
  task test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // About 40 bytes of 1.7 us each; the limit leaves wide margin
  initial begin
    #400000;
    n_errors++;
    test_done();
  end
  initial begin
    i_rstn = 1'b0;
    i_wp = 1'b0;
    repeat (10) @(posedge i_clk);
    #1 i_rstn = 1'b1;
    t_wrap();
    t_prot();
    t_abort();
    test_done();
  end
endmodule // snv_slave_tb
